// file: hw/csdv1_defs.vh
// field positions, fixed values and timing counts of the card-specific data register
`ifndef CSDV1_DEFS_VH
`define CSDV1_DEFS_VH

// =====================================================================
// register geometry
`define CSDV1_WIDTH              128
`define CSDV1_IMAGE_BITS         8'd128

// =====================================================================
// fixed fields
`define CSDV1_STRUCT_VERSION     2'h0
`define CSDV1_RESERVED6          6'h00
`define CSDV1_RESERVED2          2'h0
`define CSDV1_RESERVED5          5'h00
`define CSDV1_PARTIAL_READ       1'h1
`define CSDV1_LAST_BIT           1'h1

// =====================================================================
// transfer-rate codes
`define CSDV1_RATE_DEFAULT       8'h32
`define CSDV1_RATE_HIGH_SPEED    8'h5a

// =====================================================================
// positions of the writable fields
`define CSDV1_LAYOUT_GROUP_BIT   15
`define CSDV1_COPY_BIT           14
`define CSDV1_PERM_LOCK_BIT      13
`define CSDV1_TEMP_LOCK_BIT      12
`define CSDV1_LAYOUT_HI          11
`define CSDV1_LAYOUT_LO          10
`define CSDV1_SPARE_HI           9
`define CSDV1_SPARE_LO           8
`define CSDV1_CRC_HI             7
`define CSDV1_CRC_LO             1

// bits that software may alter (15:8 and 7:1); all others are read-only
`define CSDV1_PROG_MASK          128'h0000_0000_0000_0000_0000_0000_0000_fffe
// bits that accept one programming only (15:13 and 11:10)
`define CSDV1_ONCE_MASK          128'h0000_0000_0000_0000_0000_0000_0000_ec00

// =====================================================================
// block length and capacity limits
`define CSDV1_BLOCK_EXP_MIN      9
`define CSDV1_BLOCK_EXP_MAX      11
`define CSDV1_MAX_SECTORS        4153344
`define CSDV1_SIZE_CODE_BIAS     2

// =====================================================================
// clock-dependent access time unit, in host clock cycles
`define CSDV1_CLOCKED_UNIT       15'd100

`endif

// file: hw/csdv1_register_bank.v
// card-specific data register (layout 1.0) with its serial program path
//
// Behaviour
// - 128-bit register; top two bits version 00b, next six bits read zero.
// - multi-bit fields are unsigned binary, most significant bit first.
// - async access byte: unit in bits 2:0, mantissa in 6:3, bit 7 reserved.
// - clocked access byte counts 100 host cycles; bytes sit at 111:104 and 119:112.
// - transfer byte: rate unit in bits 2:0, mantissa in 6:3, same table.
// - default timing mode reports transfer byte 032h, i.e. 25 MHz.
// - high-speed mode reports 05Ah; back to 032h when timing reverts.
// - command-class bit n set exactly when class n is supported.
// - read block exponent 9 to 11 only; write exponent always equals it.
// - partial-read bit always reads 1; short read blocks accepted.
// - bit 78 says whether a write block may cross a physical boundary.
// - bit 77 says whether a read block may cross a physical boundary.
// - driver-stage bit reads 1 only when a driver stage register exists.
// - a 2 GByte card must report 1024-byte read blocks.
// - user area never exceeds 4,153,344 sectors.
// - erase, protect-group and size-multiplier fields at their fixed positions.
// - write factor, partial-write, reserved zeros and final 1 fixed.
// - layout, copy, permanent lock program once; temp lock, spare, checksum rewritable.
// - only programmable fields and the transfer byte change; programmable fields only by the program command.
`timescale 1ns/1ps
`default_nettype none
`include "csdv1_defs.vh"

module csdv1_register_bank #(
    parameter [7:0]  ASYNC_ACCESS_TIME   = 8'h0e,
    parameter [7:0]  CLOCKED_ACCESS      = 8'h00,
    parameter [11:0] COMMAND_CLASSES     = 12'h5b5,
    parameter [3:0]  READ_BLOCK_EXP      = 4'h9,
    parameter [0:0]  WRITE_CROSS_OK      = 1'h0,
    parameter [0:0]  READ_CROSS_OK       = 1'h0,
    parameter [0:0]  DRIVER_STAGE        = 1'h0,
    parameter [11:0] DEVICE_SIZE_CODE    = 12'h7d0,
    parameter [2:0]  READ_CURR_LOW       = 3'h0,
    parameter [2:0]  READ_CURR_TOP       = 3'h0,
    parameter [2:0]  WRITE_CURR_LOW      = 3'h0,
    parameter [2:0]  WRITE_CURR_TOP      = 3'h0,
    parameter [2:0]  SIZE_MULTIPLIER     = 3'h3,
    parameter [0:0]  SINGLE_ERASE        = 1'h1,
    parameter [6:0]  ERASE_SECTOR        = 7'h7f,
    parameter [6:0]  PROTECT_GROUP_LEN   = 7'h00,
    parameter [0:0]  PROTECT_GROUP_EN    = 1'h0,
    parameter [2:0]  WRITE_SPEED_FACTOR  = 3'h2,
    parameter [0:0]  PARTIAL_WRITE       = 1'h0,
    parameter [0:0]  INIT_LAYOUT_GROUP   = 1'h0,
    parameter [0:0]  INIT_COPY           = 1'h0,
    parameter [0:0]  INIT_PERM_LOCK      = 1'h0,
    parameter [0:0]  INIT_TEMP_LOCK      = 1'h0,
    parameter [1:0]  INIT_LAYOUT         = 2'h0,
    parameter [6:0]  INIT_CRC            = 7'h00
) (
    // clock and reset
    input  wire         sys_clk,
    input  wire         rstn,
    // timing mode from the function-switch and reset command logic
    input  wire         high_speed_mode,
    // program command pins, host clock domain
    input  wire         prog_clk,
    input  wire         prog_frame,
    input  wire         prog_data,
    // register contents and status
    output reg  [127:0] card_specific_data,
    output reg  [14:0]  clocked_access_cycles,
    output reg          prog_done,
    output reg          prog_error,
    output reg          config_invalid
);

    // =================================================================
    // static checks on the fixed contents
    localparam integer BLOCK_EXP   = READ_BLOCK_EXP;
    localparam integer EXP_SHIFT   = (BLOCK_EXP >= `CSDV1_BLOCK_EXP_MIN) ?
                                     (BLOCK_EXP - `CSDV1_BLOCK_EXP_MIN) : 0;
    // sectors of 512 bytes; at most 4096 << 15 so it fits an integer
    localparam integer SECTORS     = (DEVICE_SIZE_CODE + 1) <<
                                     (SIZE_MULTIPLIER + `CSDV1_SIZE_CODE_BIAS + EXP_SHIFT);
    localparam         EXP_BAD     = (BLOCK_EXP < `CSDV1_BLOCK_EXP_MIN) ||
                                     (BLOCK_EXP > `CSDV1_BLOCK_EXP_MAX);
    localparam         SIZE_BAD    = (SECTORS > `CSDV1_MAX_SECTORS);
    localparam         MANT_BAD    = (ASYNC_ACCESS_TIME[6:3] == 4'h0) ||
                                     ASYNC_ACCESS_TIME[7];
    localparam         WRITE_BAD   = (WRITE_SPEED_FACTOR > 3'h5);
    localparam [0:0]   STATIC_BAD  = EXP_BAD || SIZE_BAD || MANT_BAD || WRITE_BAD;

    // =================================================================
    // pin synchronisation and host clock edge detection
    wire [2:0] pins_sync;
    wire       clk_s;
    wire       frame_s;
    wire       data_s;
    reg        clk_d;
    reg        frame_d;

    csdv1_sync #(
        .WIDTH     (3)
    ) u_sync (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .pin_in    ({prog_clk, prog_frame, prog_data}),
        .level_out (pins_sync)
    );

    assign clk_s   = pins_sync[2];
    assign frame_s = pins_sync[1];
    assign data_s  = pins_sync[0];

    wire clk_rise   = clk_s & ~clk_d;
    wire frame_fall = frame_d & ~frame_s;

    // delayed copies of the synchronised levels for edge finding
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            clk_d   <= 1'b0;
            frame_d <= 1'b0;
        end
        else
        begin
            clk_d   <= clk_s;
            frame_d <= frame_s;
        end
    end

    // =================================================================
    // programmable field storage
    reg       layout_group;
    reg       copy_flag;
    reg       permanent_lock;
    reg       temporary_lock;
    reg [1:0] content_layout;
    reg [1:0] spare_bits;
    reg [6:0] checksum;
    reg       once_used;

    // =================================================================
    // serial image capture, most significant bit first
    reg [127:0] shift_image;
    reg [7:0]   bit_count;

    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            shift_image <= 128'h0;
            bit_count   <= 8'h00;
        end
        else if (frame_fall)
        begin
            bit_count <= 8'h00;
        end
        else if (frame_s && clk_rise)
        begin
            shift_image <= {shift_image[126:0], data_s};
            // saturate past a full image so an overlong frame stays wrong
            if (bit_count <= `CSDV1_IMAGE_BITS)
                bit_count <= bit_count + 8'h01;
        end
    end

    // =================================================================
    // acceptance checks on a completed frame
    wire length_ok  = (bit_count == `CSDV1_IMAGE_BITS);
    wire fixed_same = ((shift_image ^ card_specific_data) & ~`CSDV1_PROG_MASK)
                      == 128'h0;
    wire once_same  = ((shift_image ^ card_specific_data) & `CSDV1_ONCE_MASK)
                      == 128'h0;
    // once-programmable fields lock after the first accepted command
    wire accept     = length_ok && fixed_same && (!once_used || once_same);

    // update of writable fields; everything else except the transfer byte never changes
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            layout_group   <= INIT_LAYOUT_GROUP;
            copy_flag      <= INIT_COPY;
            permanent_lock <= INIT_PERM_LOCK;
            temporary_lock <= INIT_TEMP_LOCK;
            content_layout <= INIT_LAYOUT;
            spare_bits     <= `CSDV1_RESERVED2;
            checksum       <= INIT_CRC;
            once_used      <= 1'b0;
        end
        else if (frame_fall && accept)
        begin
            layout_group   <= shift_image[`CSDV1_LAYOUT_GROUP_BIT];
            copy_flag      <= shift_image[`CSDV1_COPY_BIT];
            permanent_lock <= shift_image[`CSDV1_PERM_LOCK_BIT];
            content_layout <= shift_image[`CSDV1_LAYOUT_HI:`CSDV1_LAYOUT_LO];
            temporary_lock <= shift_image[`CSDV1_TEMP_LOCK_BIT];
            spare_bits     <= shift_image[`CSDV1_SPARE_HI:`CSDV1_SPARE_LO];
            // host recomputes the checksum for each change; stored as given
            checksum       <= shift_image[`CSDV1_CRC_HI:`CSDV1_CRC_LO];
            once_used      <= 1'b1;
        end
    end

    // =================================================================
    // command completion strobes
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            prog_done  <= 1'b0;
            prog_error <= 1'b0;
        end
        else
        begin
            prog_done  <= frame_fall;
            prog_error <= frame_fall & ~accept;
        end
    end

    // =================================================================
    // transfer-rate byte follows the timing mode
    wire [7:0] rate_code = high_speed_mode ? `CSDV1_RATE_HIGH_SPEED
                                           : `CSDV1_RATE_DEFAULT;

    // =================================================================
    // assembled register image, msb first
    wire [127:0] next_image = {
        `CSDV1_STRUCT_VERSION,        // 127:126
        `CSDV1_RESERVED6,             // 125:120
        ASYNC_ACCESS_TIME,            // 119:112
        CLOCKED_ACCESS,               // 111:104
        rate_code,                    // 103:96
        COMMAND_CLASSES,              // 95:84
        READ_BLOCK_EXP,               // 83:80
        `CSDV1_PARTIAL_READ,          // 79
        WRITE_CROSS_OK,               // 78
        READ_CROSS_OK,                // 77
        DRIVER_STAGE,                 // 76
        `CSDV1_RESERVED2,             // 75:74
        DEVICE_SIZE_CODE,             // 73:62
        READ_CURR_LOW,                // 61:59
        READ_CURR_TOP,                // 58:56
        WRITE_CURR_LOW,               // 55:53
        WRITE_CURR_TOP,               // 52:50
        SIZE_MULTIPLIER,              // 49:47
        SINGLE_ERASE,                 // 46
        ERASE_SECTOR,                 // 45:39
        PROTECT_GROUP_LEN,            // 38:32
        PROTECT_GROUP_EN,             // 31
        `CSDV1_RESERVED2,             // 30:29
        WRITE_SPEED_FACTOR,           // 28:26
        READ_BLOCK_EXP,               // 25:22
        PARTIAL_WRITE,                // 21
        `CSDV1_RESERVED5,             // 20:16
        layout_group,                 // 15
        copy_flag,                    // 14
        permanent_lock,               // 13
        temporary_lock,               // 12
        content_layout,               // 11:10
        spare_bits,                   // 9:8
        checksum,                     // 7:1
        `CSDV1_LAST_BIT               // 0
    };

    // registered image so the output is glitch-free for the bus shifter
    always @(posedge sys_clk)
    begin
        if (!rstn)
            card_specific_data <= 128'h0;
        else
            card_specific_data <= next_image;
    end

    // =================================================================
    // clocked part of the access time, in host clock cycles
    wire [14:0] next_cycles = CLOCKED_ACCESS * `CSDV1_CLOCKED_UNIT;

    always @(posedge sys_clk)
    begin
        if (!rstn)
            clocked_access_cycles <= 15'h0;
        else
            clocked_access_cycles <= next_cycles;
    end

    // =================================================================
    // flags a fixed content that breaks the block, capacity, access-time or write-factor limits;
    // a 2 GByte image with 512-byte blocks overflows the size code and cannot be set; images over 4153344 sectors land here
    always @(posedge sys_clk)
    begin
        if (!rstn)
            config_invalid <= 1'b0;
        else
            config_invalid <= STATIC_BAD;
    end

endmodule // csdv1_register_bank

`default_nettype wire

// file: hw/csdv1_sync.v
// two-stage synchroniser for a group of asynchronous input pins
`timescale 1ns/1ps
`default_nettype none

module csdv1_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rstn,
    // pins in, synchronised levels out
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] meta;

    // =================================================================
    // first stage feeds only the second; nothing else may look at it
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            meta      <= {WIDTH{1'b0}};
            level_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta      <= pin_in;
            level_out <= meta;
        end
    end

endmodule // csdv1_sync

`default_nettype wire

// file: testbench/csdv1_host_model.sv
// host model that shifts program frames and reads the register contents
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// serial program host
module csdv1_host_model (
    // program pins towards the card
    output var logic prog_clk,
    output var logic prog_frame,
    output var logic prog_data
);
    // link clock idles low outside frames
    initial
    begin
        prog_clk = 1'b0;
        prog_frame = 1'b0;
        prog_data = 1'b0;
    end
    // shift the top nbits of img, 80 ns per bit, data changes on the falling edge
    task automatic send(input logic [127:0] img, input int nbits);
        int i;
        prog_frame = 1'b1;
        #83;
        for (i = 127; i > 127 - nbits; i--)
        begin
            prog_data = img[i];
            #40 prog_clk = 1'b1;
            #40 prog_clk = 1'b0;
        end
        #83;
        prog_frame = 1'b0;
        // released line shows the inverse so a stale bit never passes for data
        prog_data = ~prog_data;
    endtask
    // host view of capacity in 512-byte sectors
    function automatic longint sectors(input logic [127:0] img);
        return (longint'(img[73:62]) + 1) << (int'(img[49:47]) + int'(img[83:80]) - 7);
    endfunction
    // reserved access mantissa or block exponent makes the image unusable
    function automatic bit image_ok(input logic [127:0] img);
        return img[118:115] != 4'h0 && img[83:80] >= 4'h9 && img[83:80] <= 4'hb;
    endfunction
    // clocked part of the first-bit delay, in bus clock cycles
    function automatic int clocked_wait(input logic [127:0] img);
        return int'(img[111:104]) * 100;
    endfunction
endmodule // csdv1_host_model
`default_nettype wire

// file: testbench/csdv1_props.sv
// port checker for the card-specific data register
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// checker
module csdv1_props #(
    parameter [7:0] CLOCKED_ACCESS = 8'h00,
    parameter [3:0] READ_BLOCK_EXP = 4'h9
) (
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rstn,
    // block inputs
    input wire logic         high_speed_mode,
    input wire logic         prog_clk,
    input wire logic         prog_frame,
    input wire logic         prog_data,
    // block outputs
    input wire logic [127:0] card_specific_data,
    input wire logic [14:0]  clocked_access_cycles,
    input wire logic         prog_done,
    input wire logic         prog_error,
    input wire logic         config_invalid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // a closed frame is always answered, accepted or not
    sequence s_frame_close;
        ##[1:8] prog_done;
    endsequence
    // image loads one edge after release, so past values need two clean edges
    sequence s_settled;
        $past(rstn) && $past(rstn, 2);
    endsequence
    a_version_zero: assert property ($past(rstn) |-> card_specific_data[127:120] == 8'h00)
        else $error("version or reserved bits not zero");
    a_fixed_ones: assert property ($past(rstn) |-> card_specific_data[0] && card_specific_data[79])
        else $error("fixed one bits not set");
    a_rate_follows_mode: assert property ($past(rstn) |->
        card_specific_data[103:96] == ($past(high_speed_mode) ? 8'h5a : 8'h32))
        else $error("transfer byte does not match timing mode");
    a_write_exp_equal: assert property ($past(rstn) |-> card_specific_data[25:22] == READ_BLOCK_EXP
        && card_specific_data[83:80] == READ_BLOCK_EXP)
        else $error("block exponents differ");
    a_clocked_cycles: assert property ($past(rstn) |->
        clocked_access_cycles == {7'h00, CLOCKED_ACCESS} * 15'd100)
        else $error("clocked access cycles wrong");
    a_error_has_done: assert property (prog_error |-> prog_done)
        else $error("error without done");
    a_done_pulse: assert property (prog_done |=> !prog_done)
        else $error("done longer than one cycle");
    a_frame_answer: assert property ($fell(prog_frame) |-> s_frame_close)
        else $error("frame end not answered");
    a_readonly_hold: assert property (s_settled |-> $stable(card_specific_data[127:104])
        && $stable(card_specific_data[95:16]))
        else $error("read-only field changed");
    a_prog_only_cmd: assert property (s_settled and !$past(prog_done) |->
        $stable(card_specific_data[15:1]))
        else $error("writable field changed without a command");
endmodule // csdv1_props

bind csdv1_register_bank csdv1_props #(
    .CLOCKED_ACCESS(CLOCKED_ACCESS), .READ_BLOCK_EXP(READ_BLOCK_EXP)
) u_props (
    .sys_clk(sys_clk), .rstn(rstn), .high_speed_mode(high_speed_mode),
    .prog_clk(prog_clk), .prog_frame(prog_frame), .prog_data(prog_data),
    .card_specific_data(card_specific_data), .clocked_access_cycles(clocked_access_cycles),
    .prog_done(prog_done), .prog_error(prog_error), .config_invalid(config_invalid)
);
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the card-specific data register
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// bench top
module testbench;
    typedef struct packed {logic md; logic [15:0] low; logic [7:0] flip; logic err;
        logic [15:0] keep;} csdv1_row_t;
    logic         sys_clk;
    logic         rstn;
    logic         high_speed_mode;
    wire          prog_clk;
    wire          prog_frame;
    wire          prog_data;
    wire [127:0]  card_specific_data;
    wire [14:0]   clocked_access_cycles;
    wire          prog_done;
    wire          prog_error;
    wire          config_invalid;
    wire          over_invalid;
    int           mismatches;
    int           checks_done;
    int           k;
    // image for the parameters below with rate byte zero and reset writable bits
    localparam logic [127:0] FIXED = {8'h00, 8'h0e, 8'hff, 8'h00, 12'h5b5, 4'ha, 4'b1000, 2'b00,
        12'hfd7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 1'b1, 7'h7f, 7'h00, 1'b0, 2'b00, 3'h2, 4'ha,
        1'b0, 5'h00, 16'h0001};
    // mode, written low bits, flipped bit (0 none), refused, low bits kept
    csdv1_row_t rows [13] = '{
        {1'b0, 16'h5779, 8'd0, 1'b0, 16'h5779},  // first write locks once fields
        {1'b0, 16'h4423, 8'd0, 1'b0, 16'h4423},  // temp lock, spare, checksum
        {1'b0, 16'h6423, 8'd0, 1'b1, 16'h4423},  // permanent lock after lock
        {1'b0, 16'h4422, 8'd0, 1'b1, 16'h4423},  // last bit
        {1'b0, 16'h5423, 8'd0, 1'b0, 16'h5423},  // temp lock set again
        {1'b0, 16'h5423, 8'd100, 1'b1, 16'h5423}, // rate byte
        {1'b1, 16'h5423, 8'd0, 1'b0, 16'h5423},  // high-speed rate
        {1'b1, 16'h5423, 8'd127, 1'b1, 16'h5423}, // version
        {1'b0, 16'h5423, 8'd90, 1'b1, 16'h5423},  // command class
        {1'b0, 16'h5423, 8'd83, 1'b1, 16'h5423},  // exponent
        {1'b0, 16'h5423, 8'd78, 1'b1, 16'h5423},  // write misalign
        {1'b0, 16'h5423, 8'd77, 1'b1, 16'h5423},  // read misalign
        {1'b0, 16'h5423, 8'd76, 1'b1, 16'h5423}}; // driver stage
    csdv1_host_model host (.prog_clk(prog_clk), .prog_frame(prog_frame), .prog_data(prog_data));
    csdv1_register_bank #(
        .CLOCKED_ACCESS(8'hff), .READ_BLOCK_EXP(4'ha), .DEVICE_SIZE_CODE(12'hfd7),
        .SIZE_MULTIPLIER(3'h7)
    ) uut (
        .sys_clk(sys_clk), .rstn(rstn), .high_speed_mode(high_speed_mode),
        .prog_clk(prog_clk), .prog_frame(prog_frame), .prog_data(prog_data),
        .card_specific_data(card_specific_data), .clocked_access_cycles(clocked_access_cycles),
        .prog_done(prog_done), .prog_error(prog_error), .config_invalid(config_invalid));
    // reserved block exponent must be flagged as unusable content
    csdv1_register_bank #(
        .READ_BLOCK_EXP(4'h8)
    ) uut_over (
        .sys_clk(sys_clk), .rstn(rstn), .high_speed_mode(high_speed_mode),
        .prog_clk(prog_clk), .prog_frame(prog_frame), .prog_data(prog_data),
        .card_specific_data(), .clocked_access_cycles(), .prog_done(), .prog_error(),
        .config_invalid(over_invalid));
    // 125 MHz system clock
    always #4 sys_clk = ~sys_clk;
    function automatic logic [127:0] image(input logic md, input logic [15:0] low);
        return {FIXED[127:104], md ? 8'h5a : 8'h32, FIXED[95:16], low};
    endfunction
    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // send a frame and wait, bounded, for its done pulse
    task automatic frame(input logic [127:0] img, input int nbits, input logic err);
        int n;
        host.send(img, nbits);
        n = 0;
        while (prog_done !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n == 20)
        begin
            mismatches++;
            stop_test();
        end
        check("prog_error", err, prog_error);
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("image in reset", 128'h0, card_specific_data);
        @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        check("image after reset", image(high_speed_mode, 16'h0001), card_specific_data);
    endtask
    // guard against a hang anywhere
    initial
    begin
        #400_000;
        mismatches++;
        stop_test();
    end
    initial
    begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        high_speed_mode = 1'b0;
        mismatches = 0;
        checks_done = 0;
        do_reset();
        check("cycles", 15'd25500, clocked_access_cycles);
        check("cycles host", host.clocked_wait(card_specific_data), clocked_access_cycles);
        check("sectors", 4153344, host.sectors(card_specific_data));
        check("image usable", 1'b1, host.image_ok(card_specific_data));
        check("limit invalid", 1'b0, config_invalid);
        check("over invalid", 1'b1, over_invalid);
        $display("test reset done");
        for (k = 0; k < 13; k++)
        begin
            @(posedge sys_clk);
            high_speed_mode <= rows[k].md;
            repeat (4) @(posedge sys_clk);
            frame(image(rows[k].md, rows[k].low) ^ (128'h0 | (rows[k].flip != 8'd0) << rows[k].flip),
                128, rows[k].err);
            check("image", image(rows[k].md, rows[k].keep), card_specific_data);
            $display("test row %0d done", k);
        end
        // short frame is refused and changes nothing
        frame(image(1'b0, 16'h4423), 127, 1'b1);
        check("image short", image(1'b0, 16'h5423), card_specific_data);
        $display("test short frame done");
        // reset in mid-run brings back the initial writable bits
        do_reset();
        $display("test second reset done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
